// ===== design/i2c_readback_consts.svh
// Constants of the sensor I2C readback port
`ifndef I2C_READBACK_CONSTS_SVH
`define I2C_READBACK_CONSTS_SVH

// Register indices (byte address on the register port is four times the index)
`define IDX_CFG        8'h02
`define IDX_LOOP       8'h27
`define IDX_MEAS_A     8'h28
`define IDX_MEAS_B     8'h29
`define IDX_STAT       8'h30
`define IDX_RST        8'h00

// Register port address layout
`define BUS_AW         10
`define BUS_IDX_HI     9
`define BUS_IDX_LO     2

// Configuration word fields
`define CFG_CRC_BIT    18
`define CFG_ADDR_HI    16
`define CFG_ADDR_LO    10
`define CFG_RST        32'h0000_0000

// Loop-select field and codes
`define LOOP_HI        3
`define LOOP_LO        2
`define LOOP_RST       32'h0000_0000
`define LOOP_FAST      2'h1
`define LOOP_FULL      2'h2

// Target address composition
`define ADDR_UPPER     3'h6
`define SEL_CFG        4'hF
`define ADDR_RST       7'h00

// Checksum
`define CRC_POLY       8'h07
`define CRC_INIT       8'h00

// Payload lengths in bytes
`define LEN_WORD       3'h4
`define LEN_FULL       3'h6

`endif

// ===== design/i2c_readback_pkg.sv
// Types shared by the sensor I2C readback port
`include "i2c_readback_consts.svh"
package i2c_readback_pkg;

	// One measurement set from the converter side
	typedef struct packed {
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
		logic [11:0] t;
	} meas_t;

	// One fetched payload handed from the core clock to the link clock
	typedef struct packed {
		logic [47:0] data;   // Payload, first byte in bits 47:40
		logic [2:0]  len;    // Number of payload bytes
		logic        crcOn;  // Append checksum after payload
		logic [7:0]  crc;    // Checksum of index, address and payload
		logic [7:0]  idx;    // Register index the payload belongs to
		logic [6:0]  addr;   // Target address in force
	} resp_t;

	// Link-side protocol states
	typedef enum logic [3:0] {
		L_NEW,
		L_ADDR,
		L_ADDR_ACK,
		L_IDX,
		L_IDX_ACK,
		L_TX,
		L_MACK,
		L_END,
		L_SKIP
	} link_state_t;

endpackage : i2c_readback_pkg

// ===== design/crc8_unit.sv
// One-byte step of the readback checksum
`timescale 1ns/100ps
`include "i2c_readback_consts.svh"
module crc8_unit #(
	parameter logic [7:0] POLY = `CRC_POLY
) (
	input  wire logic [7:0] crcIn,   // Checksum so far
	input  wire logic [7:0] dataIn,  // Byte to fold in
	output logic      [7:0] crcOut   // Checksum after the byte
);
	if (POLY[0] != 1'b1) begin : g_chk
		$error("crc8_unit: generator must have its x^0 term set");
	end

	// Shift the byte in MSB first, no reflection
	always_comb begin
		logic [7:0] c;
		c = crcIn ^ dataIn;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ POLY) : {c[6:0], 1'b0};  // see (RL7)
		end
		crcOut = c;
	end
endmodule : crc8_unit

// ===== design/sensor_i2c_readback_port.sv
// Read side of the sensor I2C target port with register port and loop readback
//
// Overview of operation
// (RL1) Controller writes address with write bit, then the index byte, waiting for acks.
// (RL2) After index ack, controller repeats start and resends address with read bit.
// (RL3) Device returns the selected register as four bytes, bits 31:24 first.
// (RL4) Controller acks first three bytes, nacks the last and ends with stop.
// (RL5) With checksum enable set, one checksum byte follows the read data.
// (RL6) Checksum covers index byte, read address byte, then data bytes MSB first.
// (RL7) Checksum is CRC-8 with generator x^8 + x^2 + x + 1.
// (RL8) Checksum is unreflected, starts at zero, no final inversion.
// (RL9) Readback mode comes from loop-select bits 3:2 of register 0x27.
// (RL10) Codes 00 and 11 give single mode with ordinary register access.
// (RL11) Code 01 loops X, Y, Z upper 8 bits and temperature upper 6 bits.
// (RL12) Code 10 loops X, Y, Z and temperature at full 12 bits.
// (RL13) Loop modes keep cycling while acked, stop on nack and stop.
// (RL14) Single mode is the mode after reset.
// (RL15) Each select input gives two code bits, high input the upper pair.
// (RL16) Target address is 110 followed by the four select code bits.
// (RL17) Both selects at supply use address from configuration bits 16:10.
// (RL18) An ack after the last byte continues with the next register index.
// (RL19) Device acks by pulling data low in the ninth clock, never initiates.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "i2c_readback_consts.svh"
module sensor_i2c_readback_port #(
	parameter logic [7:0] POLY = `CRC_POLY
) (
	input  wire logic                      clk,          // Core clock
	input  wire logic                      rst_b,        // Asynchronous reset, active low
	input  wire logic [`BUS_AW-1:0]        busAddr,      // Register byte address
	input  wire logic [31:0]               busWrData,    // Register write data
	input  wire logic                      busWr,        // Write strobe
	input  wire logic                      busRd,        // Read strobe
	output logic      [31:0]               busRdData,    // Read data, cycle after strobe
	input  wire i2c_readback_pkg::meas_t   meas,         // Latest measurement set
	input  wire logic [1:0]                addrSelHigh,  // Resolved level of high select input
	input  wire logic [1:0]                addrSelLow,   // Resolved level of low select input
	input  wire logic                      sclClk,       // Serial clock from the controller
	input  wire logic                      sdaIn,        // Data line level
	output logic                           sdaOut,       // Data line drive value
	output logic                           sdaOe         // Data line pull enable
);
	import i2c_readback_pkg::*;

	if (POLY[0] != 1'b1) begin : g_chk
		$error("sensor_i2c_readback_port: generator must have its x^0 term set");
	end

	// ---------------- core clock domain ----------------
	logic [31:0]  cfg_r;
	logic [31:0]  loop_r;
	logic [3:0]   selS1_r;
	logic [3:0]   selS2_r;
	logic [6:0]   targetAddr_r;
	logic [31:0]  rdData_r;
	logic         reqS1_r;
	logic         reqS2_r;
	logic         reqSeen_r;
	logic         ackTgl_r;
	resp_t        resp_r;
	logic [15:0]  servedCnt_r;
	resp_t        bld;
	logic [7:0]   crcBytes [8];
	logic [7:0]   crcChain [9];

	// ---------------- link clock domain ----------------
	link_state_t  state_r;
	logic [2:0]   bitCnt_r;
	logic [7:0]   shiftIn_r;
	logic         readDir_r;
	logic         sdaPos_r;
	logic         startSeen_r;
	logic         sdaOe_r;
	logic         sdaOut_r;
	logic [7:0]   txByte_r;
	logic [47:0]  txData_r;
	resp_t        cur_r;
	logic [2:0]   bytePos_r;
	logic         crcSent_r;
	logic         reqTgl_r;
	logic [7:0]   fetchIdx_r;
	logic         respS1_r;
	logic         respS2_r;
	logic         respSeen_r;
	logic         needReq_r;
	logic         discard_r;
	logic         haveNext_r;
	resp_t        next_r;
	logic [6:0]   addrLink_r;
	logic [7:0]   byteIn;
	logic         byteDone;
	logic         addrHit;
	logic         idxEvent;
	logic         loadEvent;
	logic         wordEnd;
	logic         takeNew;
	logic         takeEvent;
	logic [7:0]   outByte;
	logic         arrival;
	logic         outstanding;

	// Register contents seen by both the register port and the serial fetch
	function automatic logic [31:0] regWord(input logic [7:0] idx);
		case (idx)
			`IDX_CFG:    regWord = cfg_r;
			`IDX_LOOP:   regWord = loop_r;
			`IDX_MEAS_A: regWord = {meas.x, meas.y, meas.z[11:4]};
			`IDX_MEAS_B: regWord = {meas.z[3:0], meas.t, 16'h0000};
			`IDX_STAT:   regWord = {targetAddr_r, loop_r[`LOOP_HI:`LOOP_LO], cfg_r[`CFG_CRC_BIT], 6'h00, servedCnt_r};
			default:     regWord = 32'h0000_0000;
		endcase
	endfunction : regWord

	// Writable configuration; both reset to single mode with checksum off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r  <= `CFG_RST;
			loop_r <= `LOOP_RST;  // see (RL14)
		end else if (busWr) begin
			case (busAddr[`BUS_IDX_HI:`BUS_IDX_LO])
				`IDX_CFG:  cfg_r  <= busWrData;
				`IDX_LOOP: loop_r <= busWrData;
				default:   ;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_r <= 32'h0000_0000;
		end else begin
			rdData_r <= busRd ? regWord(busAddr[`BUS_IDX_HI:`BUS_IDX_LO]) : 32'h0000_0000;
		end
	end

	// Two-flop synchroniser on the address-select levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			selS1_r <= 4'h0;
			selS2_r <= 4'h0;
		end else begin
			selS1_r <= {addrSelHigh, addrSelLow};  // see (RL15)
			selS2_r <= selS1_r;
		end
	end

	// Target address from the select code or the stored field
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			targetAddr_r <= `ADDR_RST;
		end else if (selS2_r == `SEL_CFG) begin
			targetAddr_r <= cfg_r[`CFG_ADDR_HI:`CFG_ADDR_LO];  // see (RL17)
		end else begin
			targetAddr_r <= {`ADDR_UPPER, selS2_r};  // see (RL16)
		end
	end

	// Build the payload for the requested index in the current mode
	always_comb begin
		bld       = '0;
		bld.idx   = fetchIdx_r;
		bld.addr  = targetAddr_r;
		bld.crcOn = cfg_r[`CFG_CRC_BIT];  // see (RL5)
		case (loop_r[`LOOP_HI:`LOOP_LO])  // see (RL9)
			`LOOP_FAST: begin
				bld.data = {meas.x[11:4], meas.y[11:4], meas.z[11:4], meas.t[11:6], 2'h0, 16'h0000};  // see (RL11)
				bld.len  = `LEN_WORD;
			end
			`LOOP_FULL: begin
				bld.data = {meas.x, meas.y, meas.z, meas.t};  // see (RL12)
				bld.len  = `LEN_FULL;
			end
			default: begin
				bld.data = {regWord(fetchIdx_r), 16'h0000};  // see (RL10) (RL3)
				bld.len  = `LEN_WORD;
			end
		endcase
		bld.crc = (bld.len == `LEN_FULL) ? crcChain[8] : crcChain[6];
	end

	// Checksum order: index, read address byte, then payload bytes
	assign crcBytes[0] = bld.idx;                // see (RL6)
	assign crcBytes[1] = {bld.addr, 1'b1};
	assign crcChain[0] = `CRC_INIT;              // see (RL8)
	for (genvar g = 0; g < 8; g++) begin : g_crc
		if (g >= 2) begin : g_dat
			assign crcBytes[g] = bld.data[47-8*(g-2) -: 8];
		end
		crc8_unit #(.POLY(POLY)) u_crc (  // see (RL7)
			.crcIn  (crcChain[g]),
			.dataIn (crcBytes[g]),
			.crcOut (crcChain[g+1])
		);
	end

	// Request toggle from the link, two-flop synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reqS1_r <= 1'b0;
			reqS2_r <= 1'b0;
		end else begin
			reqS1_r <= reqTgl_r;
			reqS2_r <= reqS1_r;
		end
	end

	// Serve each request: latch payload, answer with a toggle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reqSeen_r   <= 1'b0;
			ackTgl_r    <= 1'b0;
			resp_r      <= '0;
			servedCnt_r <= 16'h0000;
		end else if (reqS2_r != reqSeen_r) begin
			reqSeen_r   <= reqS2_r;
			resp_r      <= bld;
			ackTgl_r    <= ~ackTgl_r;
			servedCnt_r <= servedCnt_r + 16'h0001;
		end
	end

	// ================= link clock domain =================

	// Byte decode helpers
	always_comb begin
		byteIn    = {shiftIn_r[6:0], sdaIn};
		byteDone  = (bitCnt_r == 3'h7);
		addrHit   = (byteIn[7:1] == addrLink_r);
		idxEvent  = !startSeen_r && (state_r == L_IDX) && byteDone;
		loadEvent = !startSeen_r && (((state_r == L_ADDR_ACK) && readDir_r) || ((state_r == L_MACK) && !sdaIn));
		wordEnd   = (bytePos_r >= cur_r.len) && !(cur_r.crcOn && !crcSent_r);
		takeNew   = loadEvent && ((state_r == L_ADDR_ACK) || wordEnd);
		takeEvent = takeNew && haveNext_r;
		arrival   = (respS2_r != respSeen_r);
		outstanding = (reqTgl_r != respSeen_r);
	end

	// Next byte to send: payload MSB first, then checksum, then the next word
	always_comb begin
		if (takeNew) begin
			outByte = haveNext_r ? next_r.data[47:40] : 8'hFF;  // see (RL3) (RL18)
		end else if (bytePos_r < cur_r.len) begin
			outByte = txData_r[47:40];
		end else begin
			outByte = cur_r.crc;  // see (RL5)
		end
	end

	// Sample the line at each rising clock for start detection
	always_ff @(posedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			sdaPos_r <= 1'b1;
		end else begin
			sdaPos_r <= sdaIn;
		end
	end

	// Falling clock: start detection and line drive
	always_ff @(negedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			startSeen_r <= 1'b0;
			sdaOe_r     <= 1'b0;
			sdaOut_r    <= 1'b0;
		end else begin
			startSeen_r <= (sdaPos_r && !sdaIn) || (state_r == L_NEW);
			sdaOut_r    <= 1'b0;  // Open drain: only ever pulls low
			case (state_r)
				L_ADDR_ACK: sdaOe_r <= 1'b1;  // see (RL19)
				L_IDX_ACK:  sdaOe_r <= 1'b1;
				L_TX:       sdaOe_r <= !txByte_r[7];
				default:    sdaOe_r <= 1'b0;
			endcase
		end
	end

	// Protocol sequencer, advanced at each rising clock
	always_ff @(posedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			state_r   <= L_NEW;
			bitCnt_r  <= 3'h0;
			shiftIn_r <= 8'h00;
			readDir_r <= 1'b0;
		end else if (startSeen_r) begin
			state_r   <= L_ADDR;
			bitCnt_r  <= 3'h1;
			shiftIn_r <= {7'h00, sdaIn};
		end else begin
			case (state_r)
				L_ADDR: begin
					bitCnt_r  <= bitCnt_r + 3'h1;
					shiftIn_r <= byteIn;
					if (byteDone) begin
						readDir_r <= byteIn[0];  // see (RL2)
						state_r   <= addrHit ? L_ADDR_ACK : L_SKIP;
					end
				end
				L_ADDR_ACK: begin
					bitCnt_r <= 3'h0;
					state_r  <= readDir_r ? L_TX : L_IDX;
				end
				L_IDX: begin
					bitCnt_r  <= bitCnt_r + 3'h1;
					shiftIn_r <= byteIn;
					if (byteDone) begin
						state_r <= L_IDX_ACK;  // see (RL1)
					end
				end
				L_IDX_ACK: state_r <= L_SKIP;  // A repeated start reopens the frame
				L_TX: begin
					bitCnt_r <= bitCnt_r + 3'h1;
					if (byteDone) begin
						state_r <= L_MACK;
					end
				end
				L_MACK: begin
					bitCnt_r <= 3'h0;
					state_r  <= sdaIn ? L_END : L_TX;  // see (RL4) (RL13)
				end
				L_END:   state_r <= L_NEW;  // Stop or restart clock follows the nack
				default: state_r <= state_r;
			endcase
		end
	end

	// Transmit datapath: byte shifter and current payload
	always_ff @(posedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			txByte_r  <= 8'hFF;
			txData_r  <= 48'h0;
			cur_r     <= '0;
			bytePos_r <= 3'h0;
			crcSent_r <= 1'b0;
		end else if (loadEvent) begin
			txByte_r <= outByte;
			if (takeNew) begin
				if (haveNext_r) begin
					cur_r     <= next_r;
					txData_r  <= {next_r.data[39:0], 8'h00};
					bytePos_r <= 3'h1;
					crcSent_r <= 1'b0;
				end else begin
					bytePos_r <= cur_r.len;  // Underrun: release the line
					crcSent_r <= 1'b1;
				end
			end else if (bytePos_r < cur_r.len) begin
				txData_r  <= {txData_r[39:0], 8'h00};
				bytePos_r <= bytePos_r + 3'h1;
			end else begin
				crcSent_r <= 1'b1;
			end
		end else if (!startSeen_r && state_r == L_TX) begin
			txByte_r <= {txByte_r[6:0], 1'b1};
		end
	end

	// Answer toggle from the core, two-flop synchroniser
	always_ff @(posedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			respS1_r <= 1'b0;
			respS2_r <= 1'b0;
		end else begin
			respS1_r <= ackTgl_r;
			respS2_r <= respS1_r;
		end
	end

	// Prefetch: keep one payload ready ahead of the controller
	// A start with no fetch outstanding also refetches, so a changed target address reaches the link before the address byte ends
	always_ff @(posedge sclClk or negedge rst_b) begin
		if (!rst_b) begin
			reqTgl_r   <= 1'b0;
			respSeen_r <= 1'b0;
			needReq_r  <= 1'b1;
			discard_r  <= 1'b0;
			haveNext_r <= 1'b0;
			next_r     <= '0;
			addrLink_r <= `ADDR_RST;
			fetchIdx_r <= `IDX_RST;
		end else begin
			if (arrival) begin
				respSeen_r <= respS2_r;
				addrLink_r <= resp_r.addr;
				discard_r  <= 1'b0;
				if (!discard_r && !idxEvent) begin
					next_r     <= resp_r;
					haveNext_r <= 1'b1;
				end
			end
			if (idxEvent) begin
				fetchIdx_r <= byteIn;  // see (RL1)
				needReq_r  <= 1'b1;
				haveNext_r <= 1'b0;
				if (outstanding && !arrival) begin
					discard_r <= 1'b1;
				end
			end else if (takeEvent) begin
				fetchIdx_r <= next_r.idx + 8'h01;  // see (RL18) (RL13)
				needReq_r  <= 1'b1;
				haveNext_r <= 1'b0;
			end else if ((needReq_r || startSeen_r) && !outstanding && !arrival) begin  // see (RL16) (RL17)
				reqTgl_r  <= ~reqTgl_r;
				needReq_r <= 1'b0;
			end
		end
	end

	assign busRdData = rdData_r;
	assign sdaOe     = sdaOe_r;
	assign sdaOut    = sdaOut_r;
endmodule : sensor_i2c_readback_port

// ===== tb/i2c_ctrl_model.sv
// Behavioural I2C bus controller for the serial side of the port
`timescale 1ns/100ps
module i2c_ctrl_model (
	output logic      sclClk, // Serial clock, high when idle
	output logic      sdaLow, // High pulls SDA low
	input  wire logic sda     // Resolved data line
);
	// Bus idle, both lines released
	initial begin
		sclClk = 1'b1;
		sdaLow = 1'b0;
	end
	// Start or repeated start; the extra rise lets the port see SDA high
	task automatic start();
		sclClk = 1'b0;
		sdaLow = 1'b0;
		#16;
		sclClk = 1'b1;
		#16;
		sdaLow = 1'b1;
		#16;
		sclClk = 1'b0;
		#16;
	endtask : start
	// One bit: drive while low, sample at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		sdaLow = !b;
		#16;
		sclClk = 1'b1;
		#32;
		r = sda;
		sclClk = 1'b0;
		#16;
	endtask : bit_io
	// Byte out, then read back the acknowledge bit
	task automatic put_byte(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, nak);
	endtask : put_byte
	// Byte in, then acknowledge or refuse it
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(last, r);
	endtask : get_byte
	// Stop condition, lines left released
	task automatic stop();
		sdaLow = 1'b1;
		#16;
		sclClk = 1'b1;
		#16;
		sdaLow = 1'b0;
		#32;
	endtask : stop
endmodule : i2c_ctrl_model

// ===== tb/readback_port_chk_sva.sv
// Checker for the register port and data line drive
`timescale 1ns/100ps
`include "i2c_readback_consts.svh"
module readback_port_chk
	import i2c_readback_pkg::*;
(
	input wire logic        clk,         // Core clock
	input wire logic        rst_b,       // Reset, active low
	input wire logic [9:0]  busAddr,     // Register address
	input wire logic [31:0] busWrData,   // Write data
	input wire logic        busWr,       // Write strobe
	input wire logic        busRd,       // Read strobe
	input wire logic [31:0] busRdData,   // Read data
	input wire meas_t       meas,        // Measurements
	input wire logic [1:0]  addrSelHigh, // High select level
	input wire logic [1:0]  addrSelLow,  // Low select level
	input wire logic        sclClk,      // Serial clock
	input wire logic        sdaIn,       // Data line
	input wire logic        sdaOut,      // Data drive value
	input wire logic        sdaOe        // Data pull enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic [7:0] idx;
	// Register index of the access
	assign idx = busAddr[`BUS_IDX_HI:`BUS_IDX_LO];
	AST_RD_IDLE: assert property (!$past(busRd) |-> busRdData == 32'h0)
		else $error("read data outside answer cycle");
	AST_UNMAPPED: assert property (busRd && idx == 8'h40 |=> busRdData == 32'h0)
		else $error("unmapped read not zero");
	AST_MEAS_A: assert property (busRd && idx == `IDX_MEAS_A |=>
		busRdData == {$past(meas.x), $past(meas.y), $past(meas.z[11:4])}) else $error("measurement word wrong");
	AST_CFG_RB: assert property (busWr && idx == `IDX_CFG ##1 busRd && idx == `IDX_CFG |=>
		busRdData == $past(busWrData, 2)) else $error("config readback wrong");
	AST_CRC_EN: assert property (busWr && idx == `IDX_CFG ##1 busRd && idx == `IDX_STAT |=>
		busRdData[22] == $past(busWrData[`CFG_CRC_BIT], 2)) else $error("checksum enable flag wrong");
	AST_ADDR_PIN: assert property (($stable(addrSelHigh) && $stable(addrSelLow))[*6] ##0
		(busRd && idx == `IDX_STAT && {addrSelHigh, addrSelLow} != `SEL_CFG) |=>
		busRdData[31:25] == {`ADDR_UPPER, $past(addrSelHigh), $past(addrSelLow)}) else $error("target address wrong");
	AST_SDA_HOLD: assert property (sclClk && $past(sclClk) |-> $stable(sdaOe))
		else $error("data drive changed while clock high");
	AST_SDA_ZERO: assert property (sdaOut == 1'b0)
		else $error("data drive value not low");
	// Main scenarios reached
	cover property (busRd && idx == `IDX_MEAS_A);
	cover property ($rose(sdaOe));
	cover property (busWr && idx == `IDX_LOOP);
endmodule : readback_port_chk
bind sensor_i2c_readback_port readback_port_chk chk (.clk(clk), .rst_b(rst_b), .busAddr(busAddr),
	.busWrData(busWrData), .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .meas(meas),
	.addrSelHigh(addrSelHigh), .addrSelLow(addrSelLow), .sclClk(sclClk), .sdaIn(sdaIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe));

// ===== tb/testbench.sv
// Testbench for the sensor I2C readback port
`timescale 1ns/100ps
module testbench;
	import i2c_readback_pkg::*;
	logic        clk, rst_b, busWr, busRd, sclClk, sdaLow, sdaOut, sdaOe;
	logic [9:0]  busAddr;
	logic [31:0] busWrData, busRdData;
	logic [1:0]  addrSelHigh, addrSelLow;
	meas_t       meas;
	wire         sda;
	int          bad_count, check_count;
	localparam logic [31:0] REG_A = 32'hA5C3B7E1;
	localparam logic [31:0] REG_B = 32'h96D20000;
	localparam logic [31:0] FAST  = 32'hA53BE16C;
	localparam logic [47:0] FULL  = 48'hA5C3B7E196D2;
	// Open-drain data line with pull-up
	assign sda = (sdaOe | sdaLow) ? 1'b0 : 1'b1;
	sensor_i2c_readback_port dut (.clk(clk), .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
		.busWr(busWr), .busRd(busRd), .busRdData(busRdData), .meas(meas), .addrSelHigh(addrSelHigh),
		.addrSelLow(addrSelLow), .sclClk(sclClk), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
	i2c_ctrl_model m (.sclClk(sclClk), .sdaLow(sdaLow), .sda(sda));
	// Core clock
	always #5 clk = ~clk;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [95:0] g, input logic [95:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Register tasks, entered just after a clock edge
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		busWr <= 1'b1;
		busAddr <= {i, 2'h0};
		busWrData <= d;
		@(posedge clk);
		busWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] i, output logic [31:0] d);
		busRd <= 1'b1;
		busAddr <= {i, 2'h0};
		@(posedge clk);
		busRd <= 1'b0;
		#1;
		d = busRdData;
	endtask : rd
	function automatic logic [7:0] crc8(input logic [47:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 47; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : crc8
	// Index write, repeated start, then n bytes read, last one refused
	task automatic xfer(input logic [6:0] a, input int n, output logic [95:0] g, output logic nk);
		logic       k;
		logic [7:0] b;
		g = '0;
		@(posedge clk);
		#3;
		m.start();
		m.put_byte({a, 1'b0}, nk);
		m.put_byte(8'h28, k);
		nk |= k;
		m.start();
		m.put_byte({a, 1'b1}, k);
		nk |= k;
		for (int i = 0; i < n; i++) begin
			m.get_byte(i == n - 1, b);
			g = {g[87:0], b};
		end
		m.stop();
		@(posedge clk);
	endtask : xfer
	task automatic t_regs();
		logic [31:0] d;
		rd(8'h27, d);
		chk(d, 32'h0);
		rd(8'h40, d);
		chk(d, 32'h0);
		rd(8'h28, d);
		chk(d, REG_A);
		wr(8'h02, 32'h00045400);
		rd(8'h02, d);
		chk(d, 32'h00045400);
		wr(8'h02, 32'h00045400);
		rd(8'h30, d);
		chk({d[31:25], d[22]}, {7'h60, 1'b1});
		wr(8'h02, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_read();
		logic [95:0] g;
		logic        nk;
		xfer(7'h60, 8, g, nk);
		chk({g[63:0], nk}, {REG_A, REG_B, 1'b0});
		wr(8'h02, 32'h00040000);
		xfer(7'h60, 5, g, nk);
		chk(g[39:0], {REG_A, crc8({8'h28, 8'hC1, REG_A})});
		chk(crc8({8'h28, 8'hC3, 32'h282A2C00}), 8'h65);
		meas <= {12'h282, 12'hA2C, 12'h800, 12'h000};
		addrSelLow <= 2'h1;
		repeat (10) @(posedge clk);
		xfer(7'h61, 5, g, nk);
		chk({g[39:0], nk}, {32'h282A2C80, 8'hEC, 1'b0});
		meas <= {12'hA5C, 12'h3B7, 12'hE19, 12'h6D2};
		addrSelLow <= 2'h0;
		repeat (10) @(posedge clk);
		wr(8'h02, 32'h0);
		$display("test read done");
	endtask : t_read
	task automatic t_loop();
		logic [95:0] g;
		logic        nk;
		wr(8'h27, 32'h4);
		xfer(7'h60, 8, g, nk);
		chk(g[63:0], {FAST, FAST});
		wr(8'h27, 32'h8);
		xfer(7'h60, 12, g, nk);
		chk(g, {FULL, FULL});
		wr(8'h27, 32'hC);
		xfer(7'h60, 4, g, nk);
		chk(g[31:0], REG_A);
		wr(8'h27, 32'h0);
		$display("test loop done");
	endtask : t_loop
	task automatic t_addr();
		logic [95:0] g;
		logic [31:0] d;
		logic        nk;
		addrSelHigh <= 2'h1;
		addrSelLow <= 2'h2;
		repeat (10) @(posedge clk);
		xfer(7'h60, 1, g, nk);
		chk(nk, 1'b1);
		xfer(7'h66, 4, g, nk);
		chk({g[31:0], nk}, {REG_A, 1'b0});
		rd(8'h30, d);
		chk(d[31:25], 7'h66);
		addrSelHigh <= 2'h3;
		addrSelLow <= 2'h3;
		wr(8'h02, 32'h00005400);
		repeat (10) @(posedge clk);
		xfer(7'h15, 4, g, nk);
		chk({g[31:0], nk}, {REG_A, 1'b0});
		$display("test addr done");
	endtask : t_addr
	// Reset, then the scenarios in turn
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		busAddr = '0;
		busWrData = '0;
		busWr = 1'b0;
		busRd = 1'b0;
		addrSelHigh = 2'h0;
		addrSelLow = 2'h0;
		meas = {12'hA5C, 12'h3B7, 12'hE19, 12'h6D2};
		bad_count = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_read();
		t_loop();
		t_addr();
		end_sim();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		end_sim();
	end
endmodule : testbench
